// [shared/psf_regs.svh]
`ifndef PSF_REGS_SVH
`define PSF_REGS_SVH

// ----------------------------------------------------------------
// Rate scaling
// ----------------------------------------------------------------
`define PSF_PCT_NOMINAL 8'd100
`define PSF_PCT_MAX 8'd200
`define PSF_PCT_RST 8'd100
`define PSF_PHASE_ONE 9'd100
`define PSF_PHASE_TWO 9'd200
`define PSF_RAMP_PCT_STEP 17'd100

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define PSF_CLK_PERIOD_NS 32'd10
`define PSF_TICK_PERIOD_US 32'd1000
`define PSF_US_PER_MS 32'd1000

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define PSF_POS_RST 32'h0000_0000
`define PSF_DWELL_RST 32'h0000_0000

`endif

// [shared/psf_pkg.sv]
`default_nettype none

package psf_pkg;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef logic signed [31:0] psf_pos_t;

  typedef enum logic [2:0] {
    psf_st_moving = 3'b001,
    psf_st_dwell = 3'b010,
    psf_st_inpos = 3'b100
  } psf_state_t;

  typedef enum logic [1:0] {
    psf_idx_incr = 2'h0,
    psf_idx_abs = 2'h1,
    psf_idx_plus = 2'h2,
    psf_idx_minus = 2'h3
  } psf_idx_t;

endpackage

`default_nettype wire

// [shared/psf_rate_if.sv]
`default_nettype none

interface psf_rate_if;
  logic [7:0] target_pct;
  logic [15:0] ramp_ms;
  logic tick;
  logic [7:0] cur_pct;
  logic [1:0] steps;

  modport ctrl (output target_pct, output ramp_ms, output tick, input cur_pct, input steps);
  modport scaler (input target_pct, input ramp_ms, input tick, output cur_pct, output steps);
endinterface

`default_nettype wire

// [hw/psf_rate_scaler.sv]
`include "psf_regs.svh"
`default_nettype none

module psf_rate_scaler
  import psf_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_b_i,
  psf_rate_if.scaler rif
);

  typedef struct packed {
    logic [7:0] cur_pct;
    logic [16:0] ramp_acc;
    logic [8:0] phase;
    logic [1:0] steps;
  } psf_scl_t;

  psf_scl_t q;
  psf_scl_t d;
  logic [16:0] acc_n;
  logic [8:0] ph_n;

  // ----------------------------------------------------------------
  // Ramp toward target and fractional time accumulation
  // ----------------------------------------------------------------
  always_comb begin
    d = q;
    d.steps = 2'h0;
    acc_n = 17'h0_0000;
    ph_n = 9'h000;
    if (rif.tick) begin
      // Ramp time is milliseconds per full nominal rate; tick is 1 ms
      if (rif.cur_pct == rif.target_pct) begin
        d.ramp_acc = 17'h0_0000;
      end else if (rif.ramp_ms == 16'h0000) begin
        d.cur_pct = rif.target_pct;
      end else begin
        acc_n = q.ramp_acc + `PSF_RAMP_PCT_STEP; // RQ3
        if (acc_n >= {1'b0, rif.ramp_ms}) begin
          acc_n = acc_n - {1'b0, rif.ramp_ms};
          if (q.cur_pct < rif.target_pct) begin
            d.cur_pct = q.cur_pct + 8'h01;
          end else begin
            d.cur_pct = q.cur_pct - 8'h01;
          end
          // Ramp faster than 1% per tick is limited to 1% per tick
          if (acc_n >= {1'b0, rif.ramp_ms}) begin
            acc_n = 17'h0_0000;
          end
        end
        d.ramp_acc = acc_n;
      end
      // Remainder is kept so no time step is ever lost
      ph_n = q.phase + {1'b0, q.cur_pct}; // RQ18
      if (ph_n >= `PSF_PHASE_TWO) begin
        d.steps = 2'h2;
        d.phase = ph_n - `PSF_PHASE_TWO;
      end else if (ph_n >= `PSF_PHASE_ONE) begin
        d.steps = 2'h1;
        d.phase = ph_n - `PSF_PHASE_ONE;
      end else begin
        d.phase = ph_n;
      end
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      q <= '{cur_pct: `PSF_PCT_RST, ramp_acc: 17'h0_0000, phase: 9'h000, steps: 2'h0};
    end else begin
      q <= d;
    end
  end

  assign rif.cur_pct = q.cur_pct;
  assign rif.steps = q.steps;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_phase_bound: assert property (@(posedge mclk_i) disable iff (!rst_b_i) // RQ18
    q.phase < `PSF_PHASE_ONE) else $error("phase remainder out of range");
  chk_ramp_single: assert property (@(posedge mclk_i) disable iff (!rst_b_i) // RQ3
    (rif.tick && rif.ramp_ms != 16'h0000) |=>
      (q.cur_pct - $past(q.cur_pct) <= 8'h01 || $past(q.cur_pct) - q.cur_pct <= 8'h01))
    else $error("ramp stepped more than one percent");

endmodule

`default_nettype wire

// [hw/psf_top.sv]
// Operation
// RQ1: Virtual counts emitted at override-scaled rate
// RQ2: Motion override always active, scales all motion
// RQ3: Override changes ramp at seconds per 100%; the code ramps at milliseconds per 100% (1 ms tick)
// RQ4: In-position needs error within window
// RQ5: In-position after motion done and dwell
// RQ6: Following error is command minus feedback
// RQ7: Error fault only when check enabled
// RQ8: Following error cleared while drive disabled
// RQ9: Travel limits evaluated only when enabled
// RQ10: Plus flag while position at/above limit
// RQ11: Minus flag while position at/below limit
// RQ12: Define home loads command with home value
// RQ13: Positive rollover wraps counter to zero
// RQ14: Negative rollover wraps zero to top
// RQ15: Rollover resolved to distance decimal places
// RQ16: Absolute index takes shortest rotary path
// RQ17: Rotary plus/minus index forces direction
// RQ18: Time base from fractional phase accumulator
`include "psf_regs.svh"
`default_nettype none

module psf_top
  import psf_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire logic tick_i,
  input wire logic drive_en_i,
  input wire logic [7:0] motion_rate_pct_i,
  input wire logic [7:0] virtual_count_rate_scale_i,
  input wire logic [15:0] rate_change_ramp_time_i,
  input wire psf_pos_t cmd_delta_i,
  input wire psf_pos_t fb_delta_i,
  input wire logic motion_done_i,
  input wire psf_pos_t inpos_window_i,
  input wire logic [15:0] inpos_time_ms_i,
  input wire logic fe_check_en_i,
  input wire psf_pos_t fe_limit_i,
  input wire logic travel_lim_en_i,
  input wire psf_pos_t travel_lim_plus_i,
  input wire psf_pos_t travel_lim_minus_i,
  input wire logic define_home_i,
  input wire psf_pos_t home_pos_i,
  input wire logic rollover_en_i,
  input wire logic [23:0] rollover_units_i,
  input wire logic [2:0] dist_decimals_i,
  input wire logic idx_req_i,
  input wire psf_idx_t idx_type_i,
  input wire psf_pos_t idx_target_i,
  output psf_pos_t pos_cmd_o,
  output psf_pos_t pos_fb_o,
  output psf_pos_t ferr_o,
  output logic in_position_flag_o,
  output logic fe_fault_o,
  output logic travel_lim_plus_o,
  output logic travel_lim_minus_o,
  output psf_pos_t idx_dist_o,
  output logic idx_valid_o,
  output logic [1:0] motion_time_steps_o,
  output logic [1:0] virtual_count_steps_o,
  output logic [7:0] motion_rate_pct_o,
  output logic [7:0] virtual_rate_pct_o
);

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  function automatic psf_pos_t psf_wrap(input psf_pos_t p, input psf_pos_t r, input logic en);
    if (en && r > 0) begin
      if (p >= r) begin
        return p - r;
      end else if (p < 0) begin
        return p + r;
      end
    end
    return p;
  endfunction

  function automatic psf_pos_t psf_abs(input psf_pos_t v);
    return (v < 0) ? -v : v;
  endfunction

  function automatic logic [31:0] psf_pow10(input logic [2:0] dp);
    case (dp)
      3'h0: return 32'h0000_0001;
      3'h1: return 32'h0000_000A;
      3'h2: return 32'h0000_0064;
      3'h3: return 32'h0000_03E8;
      3'h4: return 32'h0000_2710;
      3'h5: return 32'h0001_86A0;
      default: return 32'h000F_4240;
    endcase
  endfunction

  function automatic logic [7:0] psf_clamp_pct(input logic [7:0] p);
    return (p > `PSF_PCT_MAX) ? `PSF_PCT_MAX : p;
  endfunction

  // ----------------------------------------------------------------
  // Time scalers
  // ----------------------------------------------------------------
  psf_rate_if motion_rif ();
  psf_rate_if virt_rif ();

  // Motion scaler has no bypass: always in the time path
  assign motion_rif.target_pct = psf_clamp_pct(motion_rate_pct_i); // RQ2
  assign motion_rif.ramp_ms = rate_change_ramp_time_i;
  assign motion_rif.tick = tick_i;
  assign virt_rif.target_pct = psf_clamp_pct(virtual_count_rate_scale_i); // RQ1
  assign virt_rif.ramp_ms = rate_change_ramp_time_i;
  assign virt_rif.tick = tick_i;

  psf_rate_scaler u_motion_scaler (
    .mclk_i(mclk_i),
    .rst_b_i(rst_b_i),
    .rif(motion_rif)
  );

  psf_rate_scaler u_virt_scaler (
    .mclk_i(mclk_i),
    .rst_b_i(rst_b_i),
    .rif(virt_rif)
  );

  assign motion_time_steps_o = motion_rif.steps;
  assign virtual_count_steps_o = virt_rif.steps;
  assign motion_rate_pct_o = motion_rif.cur_pct;
  assign virtual_rate_pct_o = virt_rif.cur_pct;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    psf_pos_t pos_cmd;
    psf_pos_t pos_fb;
    psf_pos_t ferr;
    psf_state_t st;
    logic [31:0] dwell_us;
    logic inpos;
    logic fault;
    logic tl_plus;
    logic tl_minus;
    psf_pos_t idx_dist;
    logic idx_valid;
  } psf_top_st_t;

  psf_top_st_t q;
  psf_top_st_t d;
  psf_pos_t roll_cnt;
  logic [63:0] roll_prod;
  logic in_window;
  logic [31:0] dwell_goal_us;
  psf_pos_t idx_d;
  psf_pos_t half_roll;

  // Rollover point expressed in position resolution units
  assign roll_prod = {40'h0, rollover_units_i} * {32'h0, psf_pow10(dist_decimals_i)}; // RQ15
  assign roll_cnt = psf_pos_t'(roll_prod[31:0]);
  assign half_roll = roll_cnt >>> 1;
  assign in_window = psf_abs(q.ferr) <= inpos_window_i; // RQ4
  assign dwell_goal_us = 32'(inpos_time_ms_i) * `PSF_US_PER_MS;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    d = q;
    d.idx_valid = 1'b0;
    idx_d = '0;

    // Position tracking with rotary wrap in both directions
    if (tick_i) begin
      d.pos_fb = psf_wrap(q.pos_fb + fb_delta_i, roll_cnt, rollover_en_i); // RQ13
      d.pos_cmd = psf_wrap(q.pos_cmd + cmd_delta_i, roll_cnt, rollover_en_i); // RQ14
      d.ferr = q.ferr + cmd_delta_i - fb_delta_i; // RQ6
    end

    // Disabled drive: command tracks feedback, no error remains
    if (!drive_en_i) begin
      d.ferr = '0; // RQ8
      d.pos_cmd = d.pos_fb;
    end

    // Define home sets command without motion; error is preserved
    if (define_home_i) begin
      d.pos_cmd = home_pos_i; // RQ12
      d.pos_fb = home_pos_i - d.ferr;
    end

    // In-position sequencing
    case (q.st)
      psf_st_moving: begin
        d.inpos = 1'b0;
        d.dwell_us = `PSF_DWELL_RST;
        if (motion_done_i && in_window) begin
          if (inpos_time_ms_i == 16'h0000) begin
            d.st = psf_st_inpos; // RQ5
            d.inpos = 1'b1;
          end else begin
            d.st = psf_st_dwell;
          end
        end
      end
      psf_st_dwell: begin
        if (!motion_done_i || !in_window) begin
          d.st = psf_st_moving;
        end else if (tick_i) begin
          d.dwell_us = q.dwell_us + `PSF_TICK_PERIOD_US;
          if (d.dwell_us >= dwell_goal_us) begin
            d.st = psf_st_inpos; // RQ5
            d.inpos = 1'b1;
          end
        end
      end
      psf_st_inpos: begin
        if (!motion_done_i || !in_window) begin
          d.st = psf_st_moving;
          d.inpos = 1'b0;
        end
      end
      default: begin
        d.st = psf_st_moving;
        d.inpos = 1'b0;
      end
    endcase

    // Following error fault latches until check or drive is dropped
    if (!fe_check_en_i || !drive_en_i) begin
      d.fault = 1'b0; // RQ7
    end else if (psf_abs(q.ferr) > fe_limit_i) begin
      d.fault = 1'b1; // RQ7
    end

    // Software travel limits follow position level, only while monitored
    d.tl_plus = 1'b0;
    d.tl_minus = 1'b0;
    if (travel_lim_en_i) begin // RQ9
      d.tl_plus = q.pos_fb >= travel_lim_plus_i; // RQ10
      d.tl_minus = q.pos_fb <= travel_lim_minus_i; // RQ11
    end

    // Index distance resolution
    if (idx_req_i) begin
      if (idx_type_i == psf_idx_incr) begin
        idx_d = idx_target_i;
      end else begin
        idx_d = idx_target_i - q.pos_cmd;
        if (rollover_en_i && roll_cnt > 0) begin
          case (idx_type_i)
            psf_idx_abs: begin
              if (idx_d > half_roll) begin
                idx_d = idx_d - roll_cnt; // RQ16
              end else if (idx_d <= -half_roll) begin
                idx_d = idx_d + roll_cnt; // RQ16
              end
            end
            psf_idx_plus: begin
              if (idx_d < 0) begin
                idx_d = idx_d + roll_cnt; // RQ17
              end
            end
            psf_idx_minus: begin
              if (idx_d > 0) begin
                idx_d = idx_d - roll_cnt; // RQ17
              end
            end
            default: begin
              idx_d = idx_d;
            end
          endcase
        end
      end
      d.idx_dist = idx_d;
      d.idx_valid = 1'b1;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      q <= '{pos_cmd: `PSF_POS_RST, pos_fb: `PSF_POS_RST, ferr: `PSF_POS_RST,
             st: psf_st_moving, dwell_us: `PSF_DWELL_RST, inpos: 1'b0, fault: 1'b0,
             tl_plus: 1'b0, tl_minus: 1'b0, idx_dist: `PSF_POS_RST, idx_valid: 1'b0};
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign pos_cmd_o = q.pos_cmd;
  assign pos_fb_o = q.pos_fb;
  assign ferr_o = q.ferr;
  assign in_position_flag_o = q.inpos;
  assign fe_fault_o = q.fault;
  assign travel_lim_plus_o = q.tl_plus;
  assign travel_lim_minus_o = q.tl_minus;
  assign idx_dist_o = q.idx_dist;
  assign idx_valid_o = q.idx_valid;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking chk_cb @(posedge mclk_i);
  endclocking
  default disable iff (!rst_b_i);

  chk_ferr_cleared: assert property (!drive_en_i |=> q.ferr == 0) // RQ8
    else $error("following error not cleared while disabled");
  chk_ferr_sign: assert property ( // RQ6
    (drive_en_i && tick_i && !define_home_i) |=>
      q.ferr == $past(q.ferr) + $past(cmd_delta_i) - $past(fb_delta_i))
    else $error("following error not command minus feedback");
  chk_fault_off: assert property (!fe_check_en_i |=> !fe_fault_o) // RQ7
    else $error("fault raised with check disabled");
  chk_fault_raise: assert property ( // RQ7
    (fe_check_en_i && drive_en_i && psf_abs(q.ferr) > fe_limit_i) |=> fe_fault_o)
    else $error("fault missed on excess error");
  chk_limits_off: assert property ( // RQ9
    !travel_lim_en_i |=> !travel_lim_plus_o && !travel_lim_minus_o)
    else $error("travel flag while limits disabled");
  chk_limit_plus: assert property ( // RQ10
    travel_lim_en_i |=> travel_lim_plus_o == ($past(q.pos_fb) >= $past(travel_lim_plus_i)))
    else $error("plus travel flag wrong");
  chk_limit_minus: assert property ( // RQ11
    travel_lim_en_i |=> travel_lim_minus_o == ($past(q.pos_fb) <= $past(travel_lim_minus_i)))
    else $error("minus travel flag wrong");
  chk_inpos_window: assert property ($rose(in_position_flag_o) |-> $past(in_window)) // RQ4
    else $error("in position outside window");
  chk_inpos_done: assert property ($rose(in_position_flag_o) |-> $past(motion_done_i)) // RQ5
    else $error("in position before motion done");
  chk_home_load: assert property (define_home_i |=> pos_cmd_o == $past(home_pos_i)) // RQ12
    else $error("home value not loaded");
  chk_wrap_range: assert property ( // RQ13
    (tick_i && rollover_en_i && roll_cnt > 0 && !define_home_i &&
     q.pos_fb >= 0 && q.pos_fb < roll_cnt && psf_abs(fb_delta_i) < roll_cnt &&
     $stable(roll_cnt)) |=> (pos_fb_o >= 0 && pos_fb_o < roll_cnt))
    else $error("feedback escaped rollover range");
  chk_idx_short: assert property ( // RQ16
    (idx_req_i && idx_type_i == psf_idx_abs && rollover_en_i && roll_cnt > 0) |=>
      (psf_abs(idx_dist_o) <= $past(half_roll) + 1))
    else $error("absolute index not shortest");

  cov_inpos: cover property ($rose(in_position_flag_o));
  cov_fault: cover property ($rose(fe_fault_o));
  cov_wrap_down: cover property (rollover_en_i && q.pos_fb == 0 && tick_i && fb_delta_i < 0);
  cov_dwell: cover property (q.st == psf_st_dwell ##1 q.st == psf_st_inpos);

endmodule

`default_nettype wire

// [verification/psf_drive_model.sv]
`default_nettype none

module psf_drive_model
  import psf_pkg::*;
(
  input wire logic stall_i,
  input wire psf_pos_t pos_cmd_i,
  input wire psf_pos_t pos_fb_i,
  output psf_pos_t fb_delta_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // Servo response
  // ----------------------------------------------------------------
  // Prompt servo closes the whole error each update; a stalled shaft holds still
  assign fb_delta_o = stall_i ? 32'sh0000_0000 : pos_cmd_i - pos_fb_i;
endmodule

`default_nettype wire

// [verification/tb.sv]
`include "psf_regs.svh"
`default_nettype none

module tb
  import psf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct {int op; int a; int b; int e1; int e2;} psf_row_t;

  logic mclk, rst_b, tick, drive_en, done, fe_en, lim_en, home, ro_en, idx_req, stall;
  logic [7:0] m_pct, v_pct, m_pct_o, v_pct_o;
  logic [15:0] ramp, dwell;
  logic [23:0] ro_units;
  logic [2:0] dp;
  psf_idx_t idx_type;
  psf_pos_t cmd_d, fb_d, window, fe_lim, lim_p, lim_m, home_pos, idx_tgt;
  psf_pos_t pos_cmd, pos_fb, ferr, idx_dist;
  logic inpos, fault, lp, lm, idx_valid;
  logic [1:0] m_steps, v_steps;
  int mismatches, n_compared, msum, vsum;
  // Rates: op 0, motion pct, virtual pct, steps over 20 ticks; index: op 1, type, target, distance
  psf_row_t rows[9] = '{'{0, 50, 200, 10, 40}, '{0, 200, 50, 40, 10}, '{0, 250, 100, 40, 20},
    '{0, 100, 100, 20, 20}, '{1, 1, 350, -20, 0}, '{1, 1, 190, 180, 0}, '{1, 2, 350, 340, 0},
    '{1, 3, 20, -350, 0}, '{1, 0, -7, -7, 0}};

  psf_top i_psf_top (.mclk_i(mclk), .rst_b_i(rst_b), .tick_i(tick), .drive_en_i(drive_en),
    .motion_rate_pct_i(m_pct), .virtual_count_rate_scale_i(v_pct),
    .rate_change_ramp_time_i(ramp), .cmd_delta_i(cmd_d), .fb_delta_i(fb_d),
    .motion_done_i(done), .inpos_window_i(window), .inpos_time_ms_i(dwell),
    .fe_check_en_i(fe_en), .fe_limit_i(fe_lim), .travel_lim_en_i(lim_en),
    .travel_lim_plus_i(lim_p), .travel_lim_minus_i(lim_m), .define_home_i(home),
    .home_pos_i(home_pos), .rollover_en_i(ro_en), .rollover_units_i(ro_units),
    .dist_decimals_i(dp), .idx_req_i(idx_req), .idx_type_i(idx_type), .idx_target_i(idx_tgt),
    .pos_cmd_o(pos_cmd), .pos_fb_o(pos_fb), .ferr_o(ferr), .in_position_flag_o(inpos),
    .fe_fault_o(fault), .travel_lim_plus_o(lp), .travel_lim_minus_o(lm),
    .idx_dist_o(idx_dist), .idx_valid_o(idx_valid), .motion_time_steps_o(m_steps),
    .virtual_count_steps_o(v_steps), .motion_rate_pct_o(m_pct_o), .virtual_rate_pct_o(v_pct_o));

  psf_drive_model i_psf_drive_model (.stall_i(stall), .pos_cmd_i(pos_cmd), .pos_fb_i(pos_fb),
    .fb_delta_o(fb_d));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic chk(input string name, input psf_pos_t seen, input psf_pos_t exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %0d seen %0d", name, exp, seen);
    end
  endtask

  task automatic do_tick(input int cd);
    @(negedge mclk);
    tick = 1'b1;
    cmd_d = cd;
    @(negedge mclk);
    tick = 1'b0;
    cmd_d = 32'sh0000_0000;
    msum += m_steps;
    vsum += v_steps;
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask

  task automatic pulse_home;
    @(negedge mclk);
    home = 1'b1;
    @(negedge mclk);
    home = 1'b0;
  endtask

  task automatic complete_run;
    if (mismatches == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Clock and watchdog
  // ----------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  initial begin
    repeat (20000) @(posedge mclk);
    mismatches++;
    complete_run();
  end

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    {rst_b, tick, done, fe_en, lim_en, home, idx_req, stall} = '0;
    drive_en = 1'b1;
    ro_en = 1'b1;
    m_pct = 8'h64;
    v_pct = 8'h64;
    {ramp, dwell} = '0;
    ro_units = 24'h00_0024;
    dp = 3'h1;
    idx_type = psf_idx_incr;
    {cmd_d, idx_tgt} = '0;
    window = 32'sh0000_0005;
    fe_lim = 32'sh0000_0014;
    lim_p = 32'sh0000_0064;
    lim_m = -32'sh0000_0064;
    home_pos = 32'sh0000_000A;
    {mismatches, n_compared, msum, vsum} = '0;
    repeat (2) @(negedge mclk);
    rst_b = 1'b1;
    chk("reset command", pos_cmd, `PSF_POS_RST);
    chk("reset in position", inpos, 0);
    chk("reset motion pct", m_pct_o, `PSF_PCT_RST);
    pulse_home();
    chk("home command", pos_cmd, 10);
    chk("home feedback", pos_fb, 10);
    foreach (rows[i]) begin
      if (rows[i].op == 0) begin
        m_pct = rows[i].a[7:0];
        v_pct = rows[i].b[7:0];
        do_tick(0);
        msum = 0;
        vsum = 0;
        repeat (20) do_tick(0);
        chk("motion steps", msum, rows[i].e1);
        chk("virtual steps", vsum, rows[i].e2);
        chk("virtual pct", v_pct_o, rows[i].b);
        chk("motion pct", m_pct_o, (rows[i].a > `PSF_PCT_MAX) ? `PSF_PCT_MAX : rows[i].a);
      end else begin
        @(negedge mclk);
        idx_req = 1'b1;
        idx_type = psf_idx_t'(rows[i].a[1:0]);
        idx_tgt = rows[i].b;
        @(negedge mclk);
        idx_req = 1'b0;
        chk("index valid", idx_valid, 1);
        chk("index distance", idx_dist, rows[i].e1);
      end
    end
    ramp = 16'h00C8;
    m_pct = 8'h6E;
    repeat (10) do_tick(0);
    chk("ramped pct", m_pct_o, 105);
    ramp = 16'h0000;
    m_pct = 8'h64;
    do_tick(0);
    chk("jump pct", m_pct_o, 100);
    stall = 1'b1;
    do_tick(5);
    done = 1'b1;
    wait_cyc(2);
    chk("in position at window", inpos, 1);
    do_tick(1);
    wait_cyc(2);
    chk("in position outside", inpos, 0);
    stall = 1'b0;
    do_tick(0);
    wait_cyc(2);
    chk("in position regained", inpos, 1);
    done = 1'b0;
    dwell = 16'h0003;
    wait_cyc(2);
    chk("in position moving", inpos, 0);
    done = 1'b1;
    do_tick(0);
    do_tick(0);
    wait_cyc(2);
    chk("in position dwell", inpos, 0);
    do_tick(0);
    wait_cyc(2);
    chk("in position after dwell", inpos, 1);
    {done, dwell} = '0;
    fe_en = 1'b1;
    stall = 1'b1;
    do_tick(20);
    chk("following error", ferr, 20);
    wait_cyc(1);
    chk("fault at limit", fault, 0);
    do_tick(1);
    wait_cyc(1);
    chk("fault over limit", fault, 1);
    fe_en = 1'b0;
    wait_cyc(2);
    chk("fault check off", fault, 0);
    do_tick(-50);
    wait_cyc(2);
    chk("fault stays off", fault, 0);
    drive_en = 1'b0;
    wait_cyc(2);
    chk("error cleared", ferr, 0);
    drive_en = 1'b1;
    stall = 1'b0;
    fe_en = 1'b1;
    do_tick(-30);
    wait_cyc(1);
    chk("fault negative", fault, 1);
    fe_en = 1'b0;
    do_tick(0);
    ro_en = 1'b0;
    lim_en = 1'b1;
    home_pos = 32'sh0000_0000;
    pulse_home();
    do_tick(100);
    do_tick(0);
    wait_cyc(2);
    chk("plus limit", lp, 1);
    do_tick(-1);
    do_tick(0);
    wait_cyc(2);
    chk("plus limit off", lp, 0);
    do_tick(-199);
    do_tick(0);
    wait_cyc(2);
    chk("minus limit", lm, 1);
    lim_en = 1'b0;
    wait_cyc(2);
    chk("limits disabled", lm, 0);
    ro_en = 1'b1;
    stall = 1'b1;
    pulse_home();
    do_tick(350);
    chk("below rollover", pos_cmd, 350);
    do_tick(20);
    chk("positive wrap", pos_cmd, 10);
    do_tick(-20);
    chk("negative wrap", pos_cmd, 350);
    rst_b = 1'b0;
    wait_cyc(1);
    chk("mid reset command", pos_cmd, `PSF_POS_RST);
    chk("mid reset virtual pct", v_pct_o, `PSF_PCT_RST);
    rst_b = 1'b1;
    do_tick(0);
    chk("steps after reset", m_steps, 1);
    chk("position after reset", pos_cmd, `PSF_POS_RST);
    complete_run();
  end
endmodule

`default_nettype wire
